// File: dv/ccr_regs_asserts.sv
`default_nettype none
module ccr_regs_asserts (
    input wire logic              clk_sys,
    input wire logic              rstn,
    input wire logic [3:0]        reg_addr,
    input wire logic [31:0]       reg_wdata,
    input wire logic              reg_wr,
    input wire logic              reg_rd,
    input wire logic [31:0]       reg_rdata,
    input wire logic              task_switch,
    input wire ccr_pkg::ccr_req_s chk_req,
    input wire ccr_pkg::ccr_chk_s chk_out,
    input wire logic              fpu_error,
    input wire logic              fpu_int_req,
    input wire logic              fpu_ext_req,
    input wire logic              wr_req,
    input wire logic              wr_hit,
    input wire logic              evict_dirty,
    input wire logic              inquiry_wb,
    input wire logic              bus_write,
    input wire logic              miss_req,
    input wire logic              line_fill,
    input wire ccr_pkg::ccr_pol_s policy
);
    timeunit 1ns;
    timeprecision 1ns;
    import ccr_pkg::*;
    logic [31:0] m;
    logic [31:0] e;
    // mirror of control words
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            m <= MCW_RESET;
            e <= EXT_RESET;
        end
        else
        begin
            m <= ((reg_wr && reg_addr == ADDR_MCW) ? ((m & ~MCW_WMASK) | (reg_wdata & MCW_WMASK)) : m)
                 | (task_switch ? 32'h0000_0008 : 32'h0000_0000);
            e <= (reg_wr && reg_addr == ADDR_EXT) ? ((e & ~EXT_WMASK) | (reg_wdata & EXT_WMASK)) : e;
        end
    end
    wire logic w_wait = m[1] & m[3];
    wire logic w_esc  = m[2] | m[3];
    wire logic w_wp   = m[16] | (chk_req.cpl == 2'h3);
    wire logic w_al   = m[18] & chk_req.align_flag & chk_req.misaligned & (chk_req.cpl == 2'h3);
    wire logic w_pv   = ((chk_req.is_read_timestamp_instr & e[2]) | (chk_req.is_read_perf_counter_instr & ~e[8])) & (chk_req.cpl != 2'h0);
    wire logic w_bw   = m[29] ? wr_req : ((wr_req & ~wr_hit) | evict_dirty | inquiry_wb);
    wire logic w_fl   = miss_req & ~m[30];
    wire logic w_pg   = m[31] & m[0];
    wire logic w_ne   = m[5];
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rstn);
    a_read_idle: assert property (!$past(reg_rd) |-> reg_rdata == 32'h0000_0000)
        else $error("read data outside its cycle");
    a_wait_fault: assert property (chk_req.valid && chk_req.kind == CCR_INS_WAIT |=>
        chk_out.dna_fault == $past(w_wait)) else $error("wait fault wrong");
    a_esc_fault: assert property (chk_req.valid && chk_req.kind == CCR_INS_ESC |=>
        chk_out.dna_fault == $past(w_esc)) else $error("escape fault wrong");
    a_switch_sets: assert property (task_switch ##1 (chk_req.valid && chk_req.kind == CCR_INS_ESC)
        |=> chk_out.dna_fault) else $error("task switch flag not set");
    a_guard_fault: assert property (chk_req.valid && chk_req.is_write && chk_req.page_ro |=>
        chk_out.wp_fault == $past(w_wp)) else $error("write guard fault wrong");
    a_align_fault: assert property (chk_req.valid |=> chk_out.align_fault == $past(w_al))
        else $error("alignment fault wrong");
    a_priv_fault: assert property (chk_req.valid |=> chk_out.priv_fault == $past(w_pv))
        else $error("privilege fault wrong");
    a_fpu_route: assert property (fpu_error |=> fpu_int_req == $past(w_ne) && fpu_ext_req != $past(w_ne))
        else $error("fpu error routed wrong");
    a_bus_write: assert property (bus_write == $past(w_bw))
        else $error("bus write wrong");
    a_fill_block: assert property (miss_req |=> line_fill == $past(w_fl))
        else $error("line fill wrong");
    a_paging_on: assert property ($stable(w_pg) [*2] |-> policy.paging == w_pg)
        else $error("paging state wrong");
endmodule
bind ccr_regs ccr_regs_asserts u_asserts (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .task_switch(task_switch),
    .chk_req(chk_req), .chk_out(chk_out), .fpu_error(fpu_error), .fpu_int_req(fpu_int_req),
    .fpu_ext_req(fpu_ext_req), .wr_req(wr_req), .wr_hit(wr_hit), .evict_dirty(evict_dirty),
    .inquiry_wb(inquiry_wb), .bus_write(bus_write), .miss_req(miss_req), .line_fill(line_fill), .policy(policy));
`default_nettype wire

// File: dv/tb.sv
`default_nettype none
module tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ccr_pkg::*;
    logic        clk_sys = 1'h0, rstn = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, task_switch = 1'h0;
    logic        page_fault = 1'h0, fpu_error = 1'h0, wr_req = 1'h0, wr_hit = 1'h0, evict_dirty = 1'h0;
    logic        inquiry_wb = 1'h0, miss_req = 1'h0, cycle_valid = 1'h0, cycle_inta = 1'h0;
    logic        pte_pcd = 1'h0, pte_pwt = 1'h0, tlb_flush_req = 1'h0;
    logic        fpu_int_req, fpu_ext_req, bus_write, line_fill, page_cache_inhibit;
    logic        page_write_through_hint, tlb_flush_all, tlb_flush_nonglobal;
    logic [3:0]  reg_addr = 4'h0, dbg_match, o;
    logic [31:0] reg_wdata = 32'h0000_0000, fault_addr = 32'h0000_0000, reg_rdata;
    logic [1:0]  dbg_access = 2'h0;
    ccr_req_s    chk_req = '0;
    ccr_chk_s    chk_out;
    ccr_pol_s    policy;
    int          bad_count = 0, compares = 0, i;
    always #20 clk_sys = ~clk_sys;
    ccr_regs dut (.clk_sys(clk_sys), .rstn(rstn), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .task_switch(task_switch),
        .page_fault(page_fault), .fault_addr(fault_addr), .chk_req(chk_req), .chk_out(chk_out),
        .fpu_error(fpu_error), .fpu_int_req(fpu_int_req), .fpu_ext_req(fpu_ext_req), .wr_req(wr_req),
        .wr_hit(wr_hit), .evict_dirty(evict_dirty), .inquiry_wb(inquiry_wb), .bus_write(bus_write),
        .miss_req(miss_req), .line_fill(line_fill), .cycle_valid(cycle_valid), .cycle_inta(cycle_inta),
        .pte_pcd(pte_pcd), .pte_pwt(pte_pwt), .page_cache_inhibit(page_cache_inhibit),
        .page_write_through_hint(page_write_through_hint), .dbg_access(dbg_access), .dbg_match(dbg_match),
        .tlb_flush_req(tlb_flush_req), .tlb_flush_all(tlb_flush_all),
        .tlb_flush_nonglobal(tlb_flush_nonglobal), .policy(policy));
    task eq(input string n, input logic [31:0] s, input logic [31:0] x);
        compares++;
        if (s !== x)
        begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", n, x, s);
        end
    endtask
    task wr(input logic [3:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr <= 1'h1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'h0;
    endtask
    task rc(input logic [3:0] a, input logic [31:0] x);
        @(posedge clk_sys);
        reg_rd <= 1'h1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'h0;
        #1 eq("reg", reg_rdata, x);
    endtask
    task ck(input logic [1:0] k, input logic [1:0] c, input logic [5:0] f);
        @(posedge clk_sys);
        chk_req <= ccr_req_s'({1'h1, k, c, f});
        @(posedge clk_sys);
        chk_req <= '0;
        #1 o = chk_out;
    endtask
    task report_and_stop;
        $display("compares %0d bad_count %0d", compares, bad_count);
        if (bad_count == 0 && compares > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    initial
    begin
        #100_000;
        bad_count++;
        report_and_stop;
    end
    initial
    begin
        repeat (8) @(posedge clk_sys);
        rstn <= 1'h1;
        rc(ADDR_MCW, MCW_RESET);
        eq("policy reset", policy, 7'h18);
        rc(ADDR_FLA, FLA_RESET);
        rc(ADDR_PDB, PDB_RESET);
        rc(ADDR_EXT, EXT_RESET);
        rc(4'hF, 32'h0000_0000);
        wr(ADDR_MCW, '1);
        rc(ADDR_MCW, MCW_RESET | MCW_WMASK);
        wr(ADDR_PDB, '1);
        rc(ADDR_PDB, PDB_WMASK);
        wr(ADDR_EXT, '1);
        rc(ADDR_EXT, EXT_WMASK);
        wr(ADDR_EXT, 32'h0000_0000);
        rc(ADDR_EXT, EXT_RESET & ~EXT_WMASK);
        for (i = 0; i < 8; i++)
        begin
            wr(ADDR_MCW, 32'(i) << 1);
            ck(CCR_INS_WAIT, 2'h0, 6'h00);
            eq("wait", o[3], i[0] & i[2]);
            ck(CCR_INS_ESC, 2'h0, 6'h00);
            eq("esc", o[3], i[1] | i[2]);
        end
        ck(CCR_INS_OTHER, 2'h0, 6'h00);
        eq("other", o, 4'h0);
        wr(ADDR_MCW, 32'h0000_0000);
        @(posedge clk_sys) task_switch <= 1'h1;
        @(posedge clk_sys)
        begin
            task_switch <= 1'h0;
            chk_req <= ccr_req_s'({1'h1, CCR_INS_ESC, 2'h0, 6'h00});
        end
        @(posedge clk_sys) chk_req <= '0;
        #1 eq("switch esc", chk_out.dna_fault, 1'h1);
        rc(ADDR_MCW, (MCW_RESET & ~MCW_WMASK) | 32'h0000_0008);
        for (i = 0; i < 8; i++)
        begin
            wr(ADDR_MCW, i[0] ? 32'h0005_0020 : 32'h0000_0000);
            ck(CCR_INS_OTHER, i[1] ? 2'h3 : 2'h0, 6'h0F);
            eq("guard", o[1], i[0] | i[1]);
            eq("align", o[0], i[0] & i[1]);
            wr(ADDR_EXT, {23'h0, i[1], 5'h0, i[0], 2'h0});
            ck(CCR_INS_OTHER, {i[2], i[2]}, 6'h20);
            eq("tsc", o[2], i[0] & i[2]);
            ck(CCR_INS_OTHER, {i[2], i[2]}, 6'h10);
            eq("pmc", o[2], !i[1] && i[2]);
            @(posedge clk_sys) fpu_error <= 1'h1;
            @(posedge clk_sys) fpu_error <= 1'h0;
            #1 eq("fpu", {fpu_int_req, fpu_ext_req}, i[0] ? 2'h2 : 2'h1);
            eq("ne policy", policy.fpu_int16, i[0]);
            wr(ADDR_EXT, {24'h0, i[2], 3'h0, i[2], 3'h0});
            @(posedge clk_sys) dbg_access <= i[1:0];
            @(posedge clk_sys) tlb_flush_req <= 1'h1;
            @(posedge clk_sys) tlb_flush_req <= 1'h0;
            #1 eq("dbg", dbg_match, (i[1:0] == 2 && !i[2]) ? 4'h0 : 4'h1 << i[1:0]);
            eq("flush", {tlb_flush_all, tlb_flush_nonglobal}, i[2] ? 2'h1 : 2'h2);
            eq("ext policy", {policy.io_bkpt, policy.global_keep}, i[2] ? 2'h3 : 2'h0);
        end
        rc(ADDR_STATUS, 32'h0000_0002);
        rc(ADDR_STATUS, 32'h0000_0000);
        for (i = 0; i < 4; i++)
        begin
            wr(ADDR_MCW, {1'h0, i[1], i[0], 29'h0});
            @(posedge clk_sys);
            wr_req <= 1'h1;
            wr_hit <= 1'h1;
            miss_req <= 1'h1;
            @(posedge clk_sys);
            wr_req <= 1'h0;
            miss_req <= 1'h0;
            #1 eq("bus", bus_write, i[0]);
            eq("fill", line_fill, !i[1]);
            eq("wt policy", policy.write_through, i[0]);
            eq("fb policy", policy.fill_block, i[1]);
        end
        wr(ADDR_MCW, 32'h0000_0000);
        @(posedge clk_sys) evict_dirty <= 1'h1;
        @(posedge clk_sys) evict_dirty <= 1'h0;
        #1 eq("evict", bus_write, 1'h1);
        @(posedge clk_sys) inquiry_wb <= 1'h1;
        @(posedge clk_sys) inquiry_wb <= 1'h0;
        #1 eq("inquiry", bus_write, 1'h1);
        @(posedge clk_sys)
        begin
            wr_req <= 1'h1;
            wr_hit <= 1'h0;
        end
        @(posedge clk_sys) wr_req <= 1'h0;
        #1 eq("miss write", bus_write, 1'h1);
        for (i = 0; i < 4; i++)
        begin
            wr(ADDR_MCW, {i[1], 30'h0, i[0]});
            @(posedge clk_sys);
            #1 eq("paging", policy.paging, i[0] & i[1]);
            eq("prot", policy.prot_mode, i[0]);
        end
        rc(ADDR_STATUS, 32'h0000_0001);
        @(posedge clk_sys);
        page_fault <= 1'h1;
        fault_addr <= 32'h1234_5678;
        @(posedge clk_sys) fault_addr <= 32'h9ABC_DEF0;
        @(posedge clk_sys) page_fault <= 1'h0;
        rc(ADDR_FLA, 32'h9ABC_DEF0);
        wr(ADDR_MCW, 32'h0000_0000);
        @(posedge clk_sys)
        begin
            page_fault <= 1'h1;
            fault_addr <= 32'h5555_0000;
        end
        @(posedge clk_sys) page_fault <= 1'h0;
        rc(ADDR_FLA, 32'h9ABC_DEF0);
        wr(ADDR_PDB, 32'h0000_0010);
        for (i = 0; i < 3; i++)
        begin
            if (i == 1)
                wr(ADDR_MCW, 32'h8000_0001);
            @(posedge clk_sys);
            cycle_valid <= 1'h1;
            cycle_inta <= (i == 2);
            pte_pwt <= 1'h1;
            @(posedge clk_sys) cycle_valid <= 1'h0;
            #1 eq("pins", {page_cache_inhibit, page_write_through_hint}, i == 1 ? 2'h1 : 2'h2);
        end
        report_and_stop;
    end
endmodule
`default_nettype wire

// File: rtl/ccr_checker_unit.sv
`default_nettype none
module ccr_checker_unit
    import ccr_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    input  wire ccr_pkg::ccr_req_s req,
    input  wire logic [31:0]       mcw,
    input  wire logic [31:0]       ext,
    output ccr_pkg::ccr_chk_s      chk
);
    logic next_dna;
    logic next_priv;
    logic next_wp;
    logic next_al;

    always_comb
    begin
        next_dna  = 1'b0;
        next_priv = 1'b0;
        next_wp   = 1'b0;
        next_al   = 1'b0;
        if (req.valid)
        begin
            if (req.kind == CCR_INS_WAIT)
                next_dna = mcw[MCW_MP] & mcw[MCW_TS];
            if (req.kind == CCR_INS_ESC)
                next_dna = mcw[MCW_EM] | mcw[MCW_TS];
            if (req.is_read_timestamp_instr && ext[EXT_TSD] && req.cpl != 2'h0)
                next_priv = 1'b1;
            if (req.is_read_perf_counter_instr && !ext[EXT_PCE] && req.cpl != 2'h0)
                next_priv = 1'b1;
            if (req.is_write && req.page_ro && (mcw[MCW_WP] || req.cpl == 2'h3))
                next_wp = 1'b1;
            next_al = mcw[MCW_AM] & req.align_flag & req.misaligned & (req.cpl == 2'h3);
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            chk <= '0;
        else
            chk <= '{dna_fault: next_dna, priv_fault: next_priv, wp_fault: next_wp, align_fault: next_al};
    end
endmodule
`default_nettype wire

// File: rtl/ccr_pkg.sv
`default_nettype none
package ccr_pkg;
    // register offsets (word addresses)
    localparam logic [3:0]  ADDR_MCW       = 4'h0;
    localparam logic [3:0]  ADDR_FLA       = 4'h2;
    localparam logic [3:0]  ADDR_PDB       = 4'h3;
    localparam logic [3:0]  ADDR_EXT       = 4'h4;
    localparam logic [3:0]  ADDR_STATUS    = 4'h8;
    // machine_control_word fields
    localparam int          MCW_PE         = 0;
    localparam int          MCW_MP         = 1;
    localparam int          MCW_EM         = 2;
    localparam int          MCW_TS         = 3;
    localparam int          MCW_RSV1       = 4;
    localparam int          MCW_NE         = 5;
    localparam int          MCW_WP         = 16;
    localparam int          MCW_AM         = 18;
    localparam int          MCW_NW         = 29;
    localparam int          MCW_CD         = 30;
    localparam int          MCW_PG         = 31;
    localparam logic [31:0] MCW_WMASK      = 32'hE005_002F;
    localparam logic [31:0] MCW_RESET      = 32'h6000_0010;
    // page_directory_base fields
    localparam int          PDB_PWT        = 3;
    localparam int          PDB_PCD        = 4;
    localparam logic [31:0] PDB_WMASK      = 32'hFFFF_F018;
    localparam logic [31:0] PDB_RESET      = 32'h0000_0000;
    // extension_control fields
    localparam int          EXT_TSD        = 2;
    localparam int          EXT_DE         = 3;
    localparam int          EXT_PGE        = 7;
    localparam int          EXT_PCE        = 8;
    localparam logic [31:0] EXT_WMASK      = 32'h0000_018C;
    localparam logic [31:0] EXT_RESET      = 32'h0000_0004;
    localparam logic [31:0] FLA_RESET      = 32'h0000_0000;
    // fault vectors
    localparam logic [7:0]  VEC_DNA        = 8'h07;
    localparam logic [7:0]  VEC_FPU        = 8'h10;

    typedef enum logic [1:0] {
        CCR_INS_OTHER = 2'h0,
        CCR_INS_WAIT  = 2'h1,
        CCR_INS_ESC   = 2'h2
    } ccr_ins_e;

    // one checked instruction or access from the core
    typedef struct packed {
        logic        valid;
        ccr_ins_e    kind;
        logic [1:0]  cpl;
        logic        is_read_timestamp_instr;
        logic        is_read_perf_counter_instr;
        logic        is_write;
        logic        page_ro;
        logic        misaligned;
        logic        align_flag;
    } ccr_req_s;

    // verdict for that instruction
    typedef struct packed {
        logic        dna_fault;
        logic        priv_fault;
        logic        wp_fault;
        logic        align_fault;
    } ccr_chk_s;

    // policy outputs to core, cache and bus
    typedef struct packed {
        logic        prot_mode;
        logic        paging;
        logic        write_through;
        logic        fill_block;
        logic        fpu_int16;
        logic        io_bkpt;
        logic        global_keep;
    } ccr_pol_s;
endpackage
`default_nettype wire

// File: rtl/ccr_regs.sv
// How it works
// - protection on bit zero, else real
// - wait faults when monitor and switched
// - task switch sets switched flag
// - soft trap faults every escape
// - switched flag faults every escape
// - internal fpu faults use vector 16
// - write guard faults read-only writes
// - alignment faults need mask and flag
// - write-through sends every write out
// - write-back writes only miss/evict/inquiry
// - fill block stops new line fills
// - paging needs paging and protection bits
// - page fault captures linear address, only when paging is active
// - second fault address overwrites first
// - directory base upper twenty bits
// - unpaged cycles drive pins from base
// - timestamp read privileged when set
// - debug access decoding with io enable
// - global pages survive flushes when set
// - perf counter read open when set
//
// The implementer's own choices: the address-and-strobe port and the register addresses.
`default_nettype none
module ccr_regs
    import ccr_pkg::*;
(
    input  wire logic              clk_sys,
    input  wire logic              rstn,
    input  wire logic [3:0]        reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [31:0]            reg_rdata,
    input  wire logic              task_switch,
    input  wire logic              page_fault,
    input  wire logic [31:0]       fault_addr,
    input  wire ccr_pkg::ccr_req_s chk_req,
    output ccr_pkg::ccr_chk_s      chk_out,
    input  wire logic              fpu_error,
    output logic                   fpu_int_req,
    output logic                   fpu_ext_req,
    input  wire logic              wr_req,
    input  wire logic              wr_hit,
    input  wire logic              evict_dirty,
    input  wire logic              inquiry_wb,
    output logic                   bus_write,
    input  wire logic              miss_req,
    output logic                   line_fill,
    input  wire logic              cycle_valid,
    input  wire logic              cycle_inta,
    input  wire logic              pte_pcd,
    input  wire logic              pte_pwt,
    output logic                   page_cache_inhibit,
    output logic                   page_write_through_hint,
    input  wire logic [1:0]        dbg_access,
    output logic [3:0]             dbg_match,
    input  wire logic              tlb_flush_req,
    output logic                   tlb_flush_all,
    output logic                   tlb_flush_nonglobal,
    output ccr_pkg::ccr_pol_s      policy
);
    import ccr_pkg::*;

    logic [31:0] machine_control_word;
    logic [31:0] fault_linear_address;
    logic [31:0] page_directory_base;
    logic [31:0] extension_control;
    logic        fpu_err_seen;
    logic        next_bus_write;
    logic        next_fill;
    logic        unpaged;
    logic        pdb_write;
    logic [3:0]  next_dbg;

    logic paging_active;
    assign paging_active = machine_control_word[MCW_PG] & machine_control_word[MCW_PE];

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            machine_control_word <= MCW_RESET;
        else
        begin
            if (reg_wr && reg_addr == ADDR_MCW)
                machine_control_word <= (reg_wdata & MCW_WMASK) | (machine_control_word & ~MCW_WMASK);
            if (task_switch)
                machine_control_word[MCW_TS] <= 1'b1;
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            fault_linear_address <= FLA_RESET;
        else if (page_fault && paging_active)
            fault_linear_address <= fault_addr;
        else if (reg_wr && reg_addr == ADDR_FLA)
            fault_linear_address <= reg_wdata;
    end

    assign pdb_write = reg_wr && reg_addr == ADDR_PDB;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            page_directory_base <= PDB_RESET;
        else if (pdb_write)
            page_directory_base <= reg_wdata & PDB_WMASK;
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            extension_control <= EXT_RESET;
        else if (reg_wr && reg_addr == ADDR_EXT)
            extension_control <= reg_wdata & EXT_WMASK;
    end

    // register read port
    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            reg_rdata <= 32'h0000_0000;
        else if (reg_rd)
        begin
            case (reg_addr)
                ADDR_MCW:    reg_rdata <= machine_control_word;
                ADDR_FLA:    reg_rdata <= fault_linear_address;
                ADDR_PDB:    reg_rdata <= page_directory_base;
                ADDR_EXT:    reg_rdata <= extension_control;
                ADDR_STATUS: reg_rdata <= {30'h0, fpu_err_seen, paging_active};
                default:     reg_rdata <= 32'h0000_0000;
            endcase
        end
        else
            reg_rdata <= 32'h0000_0000;
    end

    ccr_checker_unit u_chk
    (
        .clk_sys (clk_sys),
        .rstn    (rstn),
        .req     (chk_req),
        .mcw     (machine_control_word),
        .ext     (extension_control),
        .chk     (chk_out)
    );

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            fpu_int_req  <= 1'b0;
            fpu_ext_req  <= 1'b0;
            fpu_err_seen <= 1'b0;
        end
        else
        begin
            fpu_int_req  <= fpu_error & machine_control_word[MCW_NE];
            fpu_ext_req  <= fpu_error & ~machine_control_word[MCW_NE];
            if (fpu_error)
                fpu_err_seen <= 1'b1;
            else if (reg_rd && reg_addr == ADDR_STATUS)
                fpu_err_seen <= 1'b0;
        end
    end

    always_comb
    begin
        next_bus_write = 1'b0;
        if (machine_control_word[MCW_NW])
            next_bus_write = wr_req;
        else
            next_bus_write = (wr_req & ~wr_hit) | evict_dirty | inquiry_wb;
        next_fill = miss_req & ~machine_control_word[MCW_CD];
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            bus_write <= 1'b0;
            line_fill <= 1'b0;
        end
        else
        begin
            bus_write <= next_bus_write;
            line_fill <= next_fill;
        end
    end

    assign unpaged = cycle_inta | ~paging_active;

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            page_cache_inhibit      <= 1'b0;
            page_write_through_hint <= 1'b0;
        end
        else if (cycle_valid)
        begin
            page_cache_inhibit      <= unpaged ? page_directory_base[PDB_PCD] : pte_pcd;
            page_write_through_hint <= unpaged ? page_directory_base[PDB_PWT] : pte_pwt;
        end
    end

    always_comb
    begin
        next_dbg = 4'h0;
        case (dbg_access)
            2'h0:    next_dbg = 4'h1;
            2'h1:    next_dbg = 4'h2;
            2'h2:    next_dbg = extension_control[EXT_DE] ? 4'h4 : 4'h0;
            2'h3:    next_dbg = 4'h8;
            default: next_dbg = 4'h0;
        endcase
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            dbg_match <= 4'h0;
        else
            dbg_match <= next_dbg;
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
        begin
            tlb_flush_all       <= 1'b0;
            tlb_flush_nonglobal <= 1'b0;
        end
        else
        begin
            tlb_flush_all       <= (tlb_flush_req | pdb_write) & ~extension_control[EXT_PGE];
            tlb_flush_nonglobal <= (tlb_flush_req | pdb_write) & extension_control[EXT_PGE];
        end
    end

    always_ff @(posedge clk_sys or negedge rstn)
    begin
        if (!rstn)
            policy <= '0;
        else
        begin
            policy.prot_mode     <= machine_control_word[MCW_PE];
            policy.paging        <= paging_active;
            policy.write_through <= machine_control_word[MCW_NW];
            policy.fill_block    <= machine_control_word[MCW_CD];
            policy.fpu_int16     <= machine_control_word[MCW_NE];
            policy.io_bkpt       <= extension_control[EXT_DE];
            policy.global_keep   <= extension_control[EXT_PGE];
        end
    end
endmodule
`default_nettype wire
